// *** logic/dmpi_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmpi_regs.svh"
// Functional notes
// - Bank address pins carry the bank of each activate, read, write or precharge.
// - For load mode register, bank pins pick MR, EMR, EMR2 or EMR3.
// - A high chip select masks the command; select goes low only to issue.
// - Command address top bits decode into four active-low chip selects.
// - Row strobe, column strobe and write enable jointly encode each command.
// - Clock enable pin is active high and follows its enable input.
// - Mask bit high suppresses the byte; mask valid across both strobe edges.
// - Mask bit 0 covers data 7-0, mask bit 1 covers data 15-8.
// - Strobes driven with write data; strobe 0 for 7-0, strobe 1 for 15-8.
// - A configuration input picks single-ended or differential strobes.
// - Two memory clock pairs, each enabled separately, run freely from the link clock.
// - Termination pin follows its own enable, independent of reads and writes.
// - Output pins float during reset and take defined levels after it.
// - Data bus driven during writes and sampled during reads.
module dmpi_top
  import dmpi_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    link_clk,
  input  wire logic                    cmd_valid,
  output var  logic                    cmd_ready,
  input  wire dmpi_op_t                cmd_op,
  input  wire logic [17:0]             cmd_addr,
  input  wire logic [2:0]              cmd_bank,
  input  wire dmpi_mreg_t              cmd_mreg,
  input  wire logic [31:0]             wr_data,
  input  wire logic [3:0]              wr_mask,
  output var  logic                    cmd_done,
  output var  logic                    rd_valid,
  output var  logic [31:0]             rd_data,
  input  wire logic [1:0]              mem_clk_en,
  input  wire logic                    cke_en,
  input  wire logic                    odt_en,
  input  wire logic                    strobe_diff_en,
  output var  logic                    pin_oe,
  output var  logic [`DMPI_ADDR_W-1:0] mem_addr,
  output var  logic [`DMPI_BA_W-1:0]   mem_ba,
  output var  logic [`DMPI_CS_W-1:0]   mem_cs_n,
  output var  logic                    mem_ras_n,
  output var  logic                    mem_cas_n,
  output var  logic                    mem_we_n,
  output var  logic                    mem_cke,
  output var  logic                    mem_odt,
  output var  logic [`DMPI_DM_W-1:0]   mem_dm,
  output var  logic [1:0]              mem_ck,
  output var  logic [1:0]              mem_ck_n,
  output var  logic [`DMPI_DQ_W-1:0]   dq_out,
  output var  logic                    dq_oe,
  input  wire logic [`DMPI_DQ_W-1:0]   dq_in,
  output var  logic [1:0]              dqs_out,
  output var  logic                    dqs_oe,
  output var  logic [1:0]              dqs_n_out,
  output var  logic                    dqs_n_oe
);

  function automatic logic [`DMPI_CS_W-1:0] cs_decode(input logic [1:0] rank);
    logic [`DMPI_CS_W-1:0] sel;
    sel       = `DMPI_CS_IDLE;
    sel[rank] = 1'b0;
    return sel;
  endfunction

  function automatic logic [`DMPI_BA_W-1:0] mreg_ba(input dmpi_mreg_t m);
    logic [`DMPI_BA_W-1:0] ba;
    unique case (m)
      mreg_mr:   ba = `DMPI_BA_MR;
      mreg_emr:  ba = `DMPI_BA_EMR;
      mreg_emr2: ba = `DMPI_BA_EMR2;
      mreg_emr3: ba = `DMPI_BA_EMR3;
    endcase
    return ba;
  endfunction

  // ---------------- Request side, clk domain ----------------
  dmpi_op_t               c_op;
  logic [`DMPI_ADDR_W-1:0] c_addr;
  logic [`DMPI_BA_W-1:0]   c_ba;
  logic [`DMPI_CS_W-1:0]   c_cs_n;
  logic [31:0]             c_wdata;
  logic [3:0]              c_wmask;
  logic                    req_tog;
  logic                    ack_seen;
  logic                    ack_s;
  logic [`DMPI_CFG_W-1:0]  cfg_c;
  logic                    ack_tog;
  logic [31:0]             l_rdata;

  wire                     take     = cmd_valid & cmd_ready;
  wire                     ack_new  = ack_s ^ ack_seen;
  wire [`DMPI_BA_W-1:0]    take_ba  = (cmd_op == op_lmr) ? mreg_ba(cmd_mreg) : cmd_bank;
  wire [`DMPI_CS_W-1:0]    take_cs  = cs_decode(cmd_addr[`DMPI_RANK_LSB +: 2]);

  dmpi_sync #(.W(1)) u_ack_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (ack_tog),
    .q    (ack_s)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c_op    <= op_nop;
      c_addr  <= `DMPI_ADDR_RST;
      c_ba    <= `DMPI_BA_RST;
      c_cs_n  <= `DMPI_CS_IDLE;
      c_wdata <= 32'h0000_0000;
      c_wmask <= 4'hf;
    end else if (take) begin
      c_op    <= cmd_op;
      c_addr  <= cmd_addr[`DMPI_ADDR_W-1:0];
      c_ba    <= take_ba;
      c_cs_n  <= take_cs;
      c_wdata <= wr_data;
      c_wmask <= wr_mask;
    end
  end

  // Request toggles once per command; fields stay frozen until the ack returns
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_tog   <= 1'b0;
      ack_seen  <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      if (take)
        req_tog <= ~req_tog;
      ack_seen  <= ack_s;
      cmd_ready <= (cmd_ready & ~take) | ack_new | (~cmd_ready & ~take & (req_tog == ack_seen) & ~ack_new);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_done <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= 32'h0000_0000;
    end else begin
      cmd_done <= ack_new;
      rd_valid <= ack_new & (c_op == op_rd);
      if (ack_new & (c_op == op_rd))
        rd_data <= l_rdata;
    end
  end

  // Configuration is registered here so the link side never sees a glitch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      cfg_c <= '0;
    else
      cfg_c <= {strobe_diff_en, odt_en, cke_en, mem_clk_en};
  end

  // ---------------- Link side, link_clk domain ----------------
  logic                    lrst_q;
  logic                    lrst_n;
  logic                    lreq_s;
  logic                    lreq_seen;
  logic [`DMPI_CFG_W-1:0]  cfg_l;
  logic [`DMPI_DQ_W-1:0]   dq_s;
  dmpi_lstate_t            lstate;
  dmpi_lstate_t            next_lstate;
  logic [2:0]              lcnt;
  logic                    ck_ph;
  dmpi_op_t                l_op;
  logic [`DMPI_ADDR_W-1:0] l_addr;
  logic [`DMPI_BA_W-1:0]   l_ba;
  logic [`DMPI_CS_W-1:0]   l_cs_n;
  logic [31:0]             l_wdata;
  logic [3:0]              l_wmask;

  // Reset asserts at once and releases on the link clock
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lrst_q <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_q <= 1'b1;
      lrst_n <= lrst_q;
    end
  end

  dmpi_sync #(.W(1)) u_req_sync (
    .clk  (link_clk),
    .rstn (lrst_n),
    .d    (req_tog),
    .q    (lreq_s)
  );

  dmpi_sync #(.W(`DMPI_CFG_W)) u_cfg_sync (
    .clk  (link_clk),
    .rstn (lrst_n),
    .d    (cfg_c),
    .q    (cfg_l)
  );

  dmpi_sync #(.W(`DMPI_DQ_W)) u_dq_sync (
    .clk  (link_clk),
    .rstn (lrst_n),
    .d    (dq_in),
    .q    (dq_s)
  );

  dmpi_cmd_if cif ();
  assign cif.op = l_op;

  dmpi_cmd_enc u_enc (
    .cif (cif)
  );

  wire       new_req  = (lreq_s != lreq_seen) && (lstate == ls_idle);
  wire       cnt_zero = (lcnt == 3'h0);
  wire [1:0] cfg_ck   = cfg_l[1:0];
  wire       cfg_cke  = cfg_l[2];
  wire       cfg_odt  = cfg_l[3];
  wire       cfg_diff = cfg_l[4];

  always_comb begin
    next_lstate = lstate;
    unique case (lstate)
      ls_idle:  if (new_req) next_lstate = ls_cmd;
      ls_cmd: begin
        if (l_op == op_wr)
          next_lstate = ls_wwait;
        else if (l_op == op_rd)
          next_lstate = ls_rwait;
        else
          next_lstate = ls_ack;
      end
      ls_wwait: if (cnt_zero) next_lstate = ls_wpre;
      ls_wpre:  next_lstate = ls_wb0;
      ls_wb0:   next_lstate = ls_wb1;
      ls_wb1:   next_lstate = ls_ack;
      ls_rwait: if (cnt_zero) next_lstate = ls_rb0;
      ls_rb0:   next_lstate = ls_rb1;
      ls_rb1:   next_lstate = ls_ack;
      ls_ack:   next_lstate = ls_idle;
    endcase
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n)
      lstate <= ls_idle;
    else
      lstate <= next_lstate;
  end

  wire [2:0] next_lcnt = (lstate == ls_cmd) ? ((l_op == op_wr) ? `DMPI_WR_WAIT : `DMPI_RD_WAIT) :
                         (cnt_zero ? 3'h0 : lcnt - 3'h1);

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n)
      lcnt <= 3'h0;
    else
      lcnt <= next_lcnt;
  end

  // Request fields are stable here because the clk side waits for the ack
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lreq_seen <= 1'b0;
      l_op      <= op_nop;
      l_addr    <= `DMPI_ADDR_RST;
      l_ba      <= `DMPI_BA_RST;
      l_cs_n    <= `DMPI_CS_IDLE;
      l_wdata   <= 32'h0000_0000;
      l_wmask   <= 4'hf;
    end else if (new_req) begin
      lreq_seen <= lreq_s;
      l_op      <= c_op;
      l_addr    <= c_addr;
      l_ba      <= c_ba;
      l_cs_n    <= c_cs_n;
      l_wdata   <= c_wdata;
      l_wmask   <= c_wmask;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      l_rdata <= 32'h0000_0000;
      ack_tog <= 1'b0;
    end else begin
      if (lstate == ls_rb0)
        l_rdata[15:0] <= dq_s;
      if (lstate == ls_rb1)
        l_rdata[31:16] <= dq_s;
      if (lstate == ls_ack)
        ack_tog <= ~ack_tog;
    end
  end

  // Pin next values
  wire                    issue      = (lstate == ls_cmd);
  wire                    wbeat      = (lstate == ls_wb0) | (lstate == ls_wb1);
  wire                    wstrobe    = wbeat | (lstate == ls_wpre);
  // A no-operation request stays deselected so the memory sees no command
  wire [`DMPI_CS_W-1:0]   next_cs_n  = (issue && l_op != op_nop) ? l_cs_n : `DMPI_CS_IDLE;
  wire                    next_ras_n = issue ? cif.ras_n : 1'b1;
  wire                    next_cas_n = issue ? cif.cas_n : 1'b1;
  wire                    next_we_n  = issue ? cif.we_n : 1'b1;
  wire [`DMPI_DQ_W-1:0]   next_dq    = (lstate == ls_wb1) ? l_wdata[31:16] : l_wdata[15:0];
  wire [`DMPI_DM_W-1:0]   next_dm    = (lstate == ls_wb0) ? l_wmask[1:0] :
                                       (lstate == ls_wb1) ? l_wmask[3:2] : `DMPI_DM_RST;
  wire [1:0]              next_dqs   = {2{lstate == ls_wb0}};

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_oe    <= 1'b0;
      mem_addr  <= `DMPI_ADDR_RST;
      mem_ba    <= `DMPI_BA_RST;
      mem_cs_n  <= `DMPI_CS_IDLE;
      mem_ras_n <= 1'b1;
      mem_cas_n <= 1'b1;
      mem_we_n  <= 1'b1;
    end else begin
      pin_oe    <= 1'b1;
      mem_cs_n  <= next_cs_n;
      mem_ras_n <= next_ras_n;
      mem_cas_n <= next_cas_n;
      mem_we_n  <= next_we_n;
      if (issue) begin
        mem_addr <= l_addr;
        mem_ba   <= l_ba;
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      mem_cke <= 1'b0;
      mem_odt <= 1'b0;
      mem_dm  <= `DMPI_DM_RST;
    end else begin
      mem_cke <= cfg_cke;
      mem_odt <= cfg_odt;
      mem_dm  <= next_dm;
    end
  end

  // Clock pairs run from reset release, low while disabled
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ck_ph    <= 1'b0;
      mem_ck   <= 2'h0;
      mem_ck_n <= 2'h0;
    end else begin
      ck_ph    <= ~ck_ph;
      mem_ck   <= cfg_ck & {2{ck_ph}};
      mem_ck_n <= cfg_ck & {2{~ck_ph}};
    end
  end

  // Data and strobes float outside write bursts so reads never collide
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      dq_out    <= '0;
      dq_oe     <= 1'b0;
      dqs_out   <= 2'h0;
      dqs_oe    <= 1'b0;
      dqs_n_out <= 2'h3;
      dqs_n_oe  <= 1'b0;
    end else begin
      dq_out    <= next_dq;
      dq_oe     <= wbeat;
      dqs_out   <= next_dqs;
      dqs_oe    <= wstrobe;
      dqs_n_out <= ~next_dqs;
      dqs_n_oe  <= wstrobe & cfg_diff;
    end
  end

endmodule
`default_nettype wire

// *** logic/dmpi_regs.svh ***
`ifndef DMPI_REGS_SVH
`define DMPI_REGS_SVH

`define DMPI_ADDR_W    16
`define DMPI_BA_W      3
`define DMPI_CS_W      4
`define DMPI_DQ_W      16
`define DMPI_DM_W      2
`define DMPI_RANK_LSB  16
`define DMPI_CFG_W     5

`define DMPI_CMD_NOP   3'h7
`define DMPI_CMD_ACT   3'h3
`define DMPI_CMD_RD    3'h5
`define DMPI_CMD_WR    3'h4
`define DMPI_CMD_PRE   3'h2
`define DMPI_CMD_LMR   3'h0
`define DMPI_CMD_REF   3'h1

`define DMPI_BA_MR     3'h0
`define DMPI_BA_EMR    3'h1
`define DMPI_BA_EMR2   3'h2
`define DMPI_BA_EMR3   3'h3

`define DMPI_CS_IDLE   4'hf
`define DMPI_DM_RST    2'h3
`define DMPI_ADDR_RST  16'h0000
`define DMPI_BA_RST    3'h0

`define DMPI_WR_LAT    3'h3
`define DMPI_RD_LAT    3'h3
`define DMPI_WR_WAIT   (`DMPI_WR_LAT - 3'h3)
`define DMPI_RD_WAIT   (`DMPI_RD_LAT + 3'h1)

`endif

// *** logic/dmpi_pkg.sv ***
package dmpi_pkg;

  typedef enum logic [2:0] {op_nop, op_act, op_rd, op_wr, op_pre, op_lmr, op_ref} dmpi_op_t;

  typedef enum logic [1:0] {mreg_mr, mreg_emr, mreg_emr2, mreg_emr3} dmpi_mreg_t;

  typedef enum {ls_idle, ls_cmd, ls_wwait, ls_wpre, ls_wb0, ls_wb1,
                ls_rwait, ls_rb0, ls_rb1, ls_ack} dmpi_lstate_t;

endpackage

// *** logic/dmpi_cmd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dmpi_cmd_if;
  import dmpi_pkg::*;
  dmpi_op_t op;
  logic     ras_n;
  logic     cas_n;
  logic     we_n;
  modport src (output op, input ras_n, input cas_n, input we_n);
  modport enc (input op, output ras_n, output cas_n, output we_n);
endinterface
`default_nettype wire

// *** logic/dmpi_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmpi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// *** logic/dmpi_cmd_enc.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmpi_regs.svh"
module dmpi_cmd_enc
  import dmpi_pkg::*;
(
  dmpi_cmd_if.enc cif
);
  logic [2:0] code;

  always_comb begin
    unique case (cif.op)
      op_act:  code = `DMPI_CMD_ACT;
      op_rd:   code = `DMPI_CMD_RD;
      op_wr:   code = `DMPI_CMD_WR;
      op_pre:  code = `DMPI_CMD_PRE;
      op_lmr:  code = `DMPI_CMD_LMR;
      op_ref:  code = `DMPI_CMD_REF;
      default: code = `DMPI_CMD_NOP;
    endcase
  end

  assign cif.ras_n = code[2];
  assign cif.cas_n = code[1];
  assign cif.we_n  = code[0];
endmodule
`default_nettype wire

// *** test/dmpi_pin_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dmpi_regs.svh"
module dmpi_pin_checker (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  link_clk,
  input wire logic                  cmd_valid,
  input wire logic                  cmd_ready,
  input wire logic                  cmd_done,
  input wire logic                  rd_valid,
  input wire logic                  pin_oe,
  input wire logic [`DMPI_CS_W-1:0] mem_cs_n,
  input wire logic                  mem_ras_n,
  input wire logic                  mem_cas_n,
  input wire logic                  mem_we_n,
  input wire logic [`DMPI_DM_W-1:0] mem_dm,
  input wire logic [1:0]            mem_ck,
  input wire logic [1:0]            mem_ck_n,
  input wire logic                  dq_oe,
  input wire logic [1:0]            dqs_out,
  input wire logic                  dqs_oe,
  input wire logic [1:0]            dqs_n_out,
  input wire logic                  dqs_n_oe
);
  wire       sel = mem_cs_n != `DMPI_CS_IDLE;
  wire [2:0] rcw = {mem_ras_n, mem_cas_n, mem_we_n};
  a_cs_one_rank: assert property (@(posedge link_clk) disable iff (!rstn) sel |-> $onehot(~mem_cs_n))
    else $error("more than one chip select low");
  a_cs_one_cycle: assert property (@(posedge link_clk) disable iff (!rstn) sel |=> !sel)
    else $error("chip select low longer than one cycle");
  a_cs_real_cmd: assert property (@(posedge link_clk) disable iff (!rstn) sel |-> rcw != 3'h7)
    else $error("selected cycle carries no command");
  a_float_reset: assert property (@(posedge link_clk) !rstn |-> !pin_oe && !dq_oe && !dqs_oe)
    else $error("pins driven during reset");
  a_burst_after_wr: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(dq_oe) |-> $past(rcw, 3) == 3'h4 && $past(mem_cs_n, 3) != `DMPI_CS_IDLE)
    else $error("data driven without write command three cycles before");
  a_burst_two: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(dq_oe) |=> dq_oe ##1 !dq_oe && !dqs_oe)
    else $error("data burst not two beats or strobe not released");
  a_strobe_edges: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(dq_oe) |-> dqs_out == 2'h3 && $past(dqs_oe) ##1 dqs_out == 2'h0)
    else $error("strobe edges do not follow write data");
  a_dm_idle: assert property (@(posedge link_clk) disable iff (!rstn)
    pin_oe && !dq_oe |-> mem_dm == `DMPI_DM_RST)
    else $error("mask not high outside write data");
  a_dqs_diff: assert property (@(posedge link_clk) disable iff (!rstn)
    dqs_n_oe |-> dqs_oe && dqs_n_out == ~dqs_out)
    else $error("complement strobe wrong");
  a_ck_pair: assert property (@(posedge link_clk) disable iff (!rstn) (mem_ck & mem_ck_n) == 2'h0)
    else $error("clock pair legs both high");
  a_done_pulse: assert property (@(posedge clk) disable iff (!rstn) cmd_done |=> !cmd_done)
    else $error("done longer than one cycle");
  a_read_done: assert property (@(posedge clk) disable iff (!rstn) rd_valid |-> cmd_done)
    else $error("read data without done");
  a_take_once: assert property (@(posedge clk) disable iff (!rstn) cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stays high after take");
  c_write: cover property (@(posedge link_clk) disable iff (!rstn) $rose(dq_oe));
  c_read: cover property (@(posedge clk) disable iff (!rstn) rd_valid);
  c_lmr: cover property (@(posedge link_clk) disable iff (!rstn) sel && rcw == 3'h0);
endmodule
bind dmpi_top dmpi_pin_checker i_chk (.clk(clk), .rstn(rstn), .link_clk(link_clk), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_done(cmd_done), .rd_valid(rd_valid), .pin_oe(pin_oe), .mem_cs_n(mem_cs_n),
  .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_dm(mem_dm), .mem_ck(mem_ck),
  .mem_ck_n(mem_ck_n), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dqs_n_out(dqs_n_out),
  .dqs_n_oe(dqs_n_oe));
`default_nettype wire

// *** test/dmpi_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmpi_mem_model (
  input  wire logic        link_clk,
  input  wire logic [3:0]  cs_n,
  input  wire logic [2:0]  ba,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  dm,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  output logic      [15:0] dq_in
);
  logic [31:0] store [8];
  logic [2:0]  wbank = 3'h0;
  logic [2:0]  rbank = 3'h0;
  logic [2:0]  rcnt  = 3'h0;
  logic        wph   = 1'b0;
  logic [15:0] last  = 16'h0;
  wire         seen  = cs_n != 4'hf;
  wire  [2:0]  rcw   = {ras_n, cas_n, we_n};
  wire         rdrv  = rcnt == 3'h3 || rcnt == 3'h4;
  wire  [15:0] beat  = rcnt == 3'h3 ? store[rbank][15:0] : store[rbank][31:16];
  // Released bus shows a changing pattern, never the last value
  assign dq_in = dq_oe ? dq_out : rdrv ? beat : ~last;
  initial begin
    foreach (store[i]) store[i] = 32'h0;
  end
  always @(posedge link_clk) begin
    last <= dq_in;
    if (rcnt != 3'h0) rcnt <= rcnt == 3'h5 ? 3'h0 : rcnt + 3'h1;
    if (seen && rcw == 3'h5) begin
      rcnt  <= 3'h1;
      rbank <= ba;
    end
    if (seen && rcw == 3'h4) wbank <= ba;
    if (dq_oe) begin
      wph <= ~wph;
      if (!dm[0]) store[wbank][{wph, 4'h0} +: 8] <= dq_out[7:0];
      if (!dm[1]) store[wbank][{wph, 4'h8} +: 8] <= dq_out[15:8];
    end
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dmpi_pkg::*;
  logic clk, rstn, link_clk, cmd_valid, cmd_ready, cmd_done, rd_valid, cke_en, odt_en, strobe_diff_en;
  logic pin_oe, mem_ras_n, mem_cas_n, mem_we_n, mem_cke, mem_odt, dq_oe, dqs_oe, dqs_n_oe, rv;
  dmpi_op_t    cmd_op;
  dmpi_mreg_t  cmd_mreg;
  logic [17:0] cmd_addr;
  logic [2:0]  cmd_bank, mem_ba;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_mask, mem_cs_n;
  logic [1:0]  mem_clk_en, mem_dm, mem_ck, mem_ck_n, dqs_out, dqs_n_out, ck_a;
  logic [15:0] mem_addr, dq_out, dq_in;
  logic [25:0] cap;
  int          err_total, num_checks, n_cmd;
  dmpi_top i_dut (.clk, .rstn, .link_clk, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_bank, .cmd_mreg,
    .wr_data, .wr_mask, .cmd_done, .rd_valid, .rd_data, .mem_clk_en, .cke_en, .odt_en, .strobe_diff_en, .pin_oe,
    .mem_addr, .mem_ba, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_cke, .mem_odt, .mem_dm, .mem_ck,
    .mem_ck_n, .dq_out, .dq_oe, .dq_in, .dqs_out, .dqs_oe, .dqs_n_out, .dqs_n_oe);
  dmpi_mem_model i_mem (.link_clk, .cs_n(mem_cs_n), .ba(mem_ba), .ras_n(mem_ras_n), .cas_n(mem_cas_n),
    .we_n(mem_we_n), .dm(mem_dm), .dq_out, .dq_oe, .dq_in);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  // Last selected command cycle seen on the pins
  always @(negedge link_clk) if (pin_oe === 1'b1 && mem_cs_n !== 4'hf) begin
    n_cmd++;
    cap = {mem_cs_n, mem_ba, mem_ras_n, mem_cas_n, mem_we_n, mem_addr};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic issue(input dmpi_op_t op, input logic [17:0] a, input logic [2:0] b, input dmpi_mreg_t m,
                       input logic [31:0] d, input logic [3:0] k);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_addr  <= a;
    cmd_bank  <= b;
    cmd_mreg  <= m;
    wr_data   <= d;
    wr_mask   <= k;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_done !== 1'b1 && n < 400);
    rv = rd_valid;
    chk({31'h0, cmd_done}, 32'h1);
  endtask
  task automatic t_reset();
    repeat (6) @(posedge clk);
    chk({29'h0, pin_oe, dq_oe, dqs_oe}, 32'h0);
    rstn <= 1'b1;
    repeat (10) @(negedge clk);
    chk({15'h0, pin_oe, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_cke, mem_odt, mem_dm, mem_ba, mem_ck},
        {15'h0, 1'b1, 4'hf, 3'h7, 2'h0, 2'h3, 3'h0, 2'h0});
    chk({16'h0, mem_addr}, 32'h0);
  endtask
  task automatic t_config();
    @(posedge clk);
    cke_en         <= 1'b1;
    odt_en         <= 1'b1;
    mem_clk_en     <= 2'h1;
    strobe_diff_en <= 1'b1;
    repeat (10) @(negedge clk);
    chk({30'h0, mem_cke, mem_odt}, 32'h3);
    @(negedge link_clk);
    ck_a = mem_ck;
    @(negedge link_clk);
    chk({30'h0, ck_a[0] ^ mem_ck[0], ck_a[1] | mem_ck[1]}, 32'h2);
    @(posedge clk);
    odt_en <= 1'b0;
    repeat (10) @(negedge clk);
    chk({30'h0, mem_cke, mem_odt}, 32'h2);
  endtask
  task automatic t_cmds();
    int c;
    for (int i = 0; i < 4; i++) begin
      issue(i[0] ? op_pre : op_act, {i[1:0], 16'h1230 + 16'(i)}, 3'(i + 3), mreg_mr, 32'h0, 4'h0);
      chk({6'h0, cap}, {6'h0, ~(4'h1 << i), 3'(i + 3), i[0] ? 3'h2 : 3'h3, 16'h1230 + 16'(i)});
    end
    for (int m = 0; m < 4; m++) begin
      issue(op_lmr, 18'h00420, 3'h7, dmpi_mreg_t'(m), 32'h0, 4'h0);
      chk({26'h0, cap[21:16]}, {26'h0, 3'(m), 3'h0});
    end
    issue(op_ref, 18'h0, 3'h0, mreg_mr, 32'h0, 4'h0);
    chk({29'h0, cap[18:16]}, 32'h1);
    c = n_cmd;
    issue(op_nop, 18'h0, 3'h0, mreg_mr, 32'h0, 4'h0);
    chk(32'(n_cmd - c), 32'h0);
  endtask
  task automatic t_wr_rd();
    issue(op_wr, {2'h2, 16'h0040}, 3'h5, mreg_mr, 32'h1122_3344, 4'h0);
    chk({22'h0, cap[25:16]}, {22'h0, 4'hb, 3'h5, 3'h4});
    issue(op_wr, {2'h2, 16'h0040}, 3'h5, mreg_mr, 32'haabb_ccdd, 4'h6);
    issue(op_rd, {2'h2, 16'h0040}, 3'h5, mreg_mr, 32'h0, 4'h0);
    chk({22'h0, cap[25:16]}, {22'h0, 4'hb, 3'h5, 3'h5});
    chk({31'h0, rv}, 32'h1);
    chk(rd_data, 32'haa22_33dd);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  initial begin
    {cmd_valid, cke_en, odt_en, strobe_diff_en, mem_clk_en} = '0;
    rstn = 1'b1;
    {cmd_addr, cmd_bank, wr_data, wr_mask} = '0;
    {err_total, num_checks, n_cmd} = '0;
    cmd_op   = op_nop;
    cmd_mreg = mreg_mr;
    // Reset falls after time zero so every asynchronous reset sees the edge
    #1 rstn = 1'b0;
    t_reset();
    t_config();
    t_cmds();
    t_wr_rd();
    finish_test();
  end
endmodule
`default_nettype wire
